// ---- rtl/cswl_status_core.sv ----
// Purpose: Status and control words of the core with product path and return stack.
// Assumes: Decoder gives one-cycle op strobes on clock; all inputs same domain.
// Notes: Priority in one cycle: load-status over bit ops over ALU carry/shift.
//
// Operation
// [RULE_01] Primary word: pointer, excess, saturate, mask, page
// [RULE_02] Secondary word layout; reserved bits read one
// [RULE_03] Load/store words; load keeps the mask
// [RULE_04] Set/clear touches one bit only
// [RULE_05] New pointer copies old into buffer
// [RULE_06] Secondary load copies buffer into pointer
// [RULE_07] Pointer selects register; its update sources
// [RULE_08] Carry from add carry, subtract borrow
// [RULE_09] Shift-16 add sets only, subtract clears only
// [RULE_10] Carry by shifts, bit ops, load; reset one
// [RULE_11] Map select chooses RAM space; reset zero
// [RULE_12] Direct address is page over seven bits
// [RULE_13] Mask blocks maskable only, never NMI
// [RULE_14] Mask set by reset, ack, trap
// [RULE_15] Excess latch sticky until its clears
// [RULE_16] Product register keeps full product
// [RULE_17] Product scaler, no extra cycle
// [RULE_18] Return stack sixteen wide, eight deep
// [RULE_19] Operand hold feeds multiplier and counts
// [RULE_20] Fetch and data read same cycle
// [RULE_21] Shift select codes, zero fill, reset clear
// [RULE_22] Saturate enable picks clamp or wrap
// [RULE_23] Sign extend enable; reset sets
// [RULE_24] Output flag drives pin; reset sets
// [RULE_25] Unspecified fields reset to zero
`timescale 1ns/1ps
`default_nettype none
module cswl_status_core (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Status word transfer
  input wire logic load_status_op,
  input wire logic store_status_op,
  input wire logic status_sel,
  input wire logic [15:0] data_rd,
  output logic [15:0] status_store_data,
  output logic [15:0] status_word_primary,
  output logic [15:0] status_word_secondary,
  // Bit operations
  input wire logic bit_set_op,
  input wire logic bit_clear_op,
  input wire logic [2:0] bit_sel,
  // Pointer and page
  input wire logic indirect_ref_op,
  input wire logic aux_pointer_load_op,
  input wire logic modify_aux_op,
  input wire logic [2:0] aux_pointer_d,
  input wire logic page_load_op,
  input wire logic [8:0] page_pointer_d,
  input wire logic [15:0] instr_word,
  output logic [15:0] direct_addr,
  output logic [2:0] aux_pointer,
  // ALU results
  input wire logic add_op,
  input wire logic sub_op,
  input wire logic shift16,
  input wire logic alu_cout,
  input wire logic alu_overflow,
  input wire logic shift_carry_we,
  input wire logic shift_carry_d,
  input wire logic test_flag_we,
  input wire logic test_flag_d,
  input wire logic shift_sel_we,
  input wire logic [1:0] shift_sel_d,
  // Branch and interrupts
  input wire logic cond_branch_op,
  input wire logic irq_ack_cycle,
  input wire logic trap_taken,
  input wire logic maskable_irq_pend,
  input wire logic nmi_pend,
  output logic irq_take,
  // Modes
  output logic saturate_enable,
  output logic sign_extend_enable,
  output logic ram_map_select,
  output logic general_out_flag,
  // Multiplier and hold
  input wire logic hold_we,
  input wire logic mul_go,
  input wire logic mul_signed,
  output logic [31:0] product_scaled,
  output logic [15:0] operand_hold,
  output logic [3:0] dyn_shift_count,
  // Return stack
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [15:0] stack_d,
  output logic [15:0] stack_top
);
  typedef struct packed {
    logic [2:0] aux_pointer;
    logic arith_excess_latch;
    logic saturate_enable;
    logic global_irq_mask;
    logic [8:0] page_pointer;
    logic [2:0] aux_pointer_prev;
    logic ram_map_select;
    logic test_flag;
    logic sign_extend_enable;
    logic carry;
    logic general_out_flag;
    logic [1:0] product_shift_sel;
    logic [15:0] store_q;
    logic irq_take;
    logic [cswl_pkg::CSWL_STK_DEPTH-1:0][15:0] stk;
  } cswl_state_t;
  cswl_state_t s_r;
  cswl_state_t s_nxt;
  logic [15:0] word0;
  logic [15:0] word1;
  logic bit_op;
  logic bit_val;
  logic arp_we;
  cswl_mul_if mb ();
  // ==========================================
  // Word assembly
  // [RULE_01] Primary layout
  always_comb begin
    word0 = cswl_pkg::CSWL_P0_RSV_MASK;
    word0[cswl_pkg::CSWL_P0_ARP_LSB +: cswl_pkg::CSWL_ARP_W] = s_r.aux_pointer;
    word0[cswl_pkg::CSWL_P0_OV] = s_r.arith_excess_latch;
    word0[cswl_pkg::CSWL_P0_OVM] = s_r.saturate_enable;
    word0[cswl_pkg::CSWL_P0_GLOBAL_IRQ_MASK] = s_r.global_irq_mask;
    word0[cswl_pkg::CSWL_DP_W-1:0] = s_r.page_pointer;
  end
  // [RULE_02] Secondary layout, reserved ones
  always_comb begin
    word1 = cswl_pkg::CSWL_P1_RSV_MASK;
    word1[cswl_pkg::CSWL_P1_ARB_LSB +: cswl_pkg::CSWL_ARP_W] = s_r.aux_pointer_prev;
    word1[cswl_pkg::CSWL_P1_CNF] = s_r.ram_map_select;
    word1[cswl_pkg::CSWL_P1_TC] = s_r.test_flag;
    word1[cswl_pkg::CSWL_P1_SXM] = s_r.sign_extend_enable;
    word1[cswl_pkg::CSWL_P1_C] = s_r.carry;
    word1[cswl_pkg::CSWL_P1_XF] = s_r.general_out_flag;
    word1[cswl_pkg::CSWL_PM_W-1:0] = s_r.product_shift_sel;
  end
  assign bit_op = bit_set_op | bit_clear_op;
  assign bit_val = bit_set_op;
  // [RULE_07] Pointer update sources
  assign arp_we = indirect_ref_op | aux_pointer_load_op | modify_aux_op;
  // ==========================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    // [RULE_05] Old pointer into buffer
    if (arp_we) begin
      s_nxt.aux_pointer_prev = s_r.aux_pointer;
      s_nxt.aux_pointer = aux_pointer_d;
    end
    // [RULE_12] Page load
    if (page_load_op) begin
      s_nxt.page_pointer = page_pointer_d;
    end
    // [RULE_08] Carry after add or subtract
    // [RULE_09] Shift-16 form only sets or clears
    if (add_op | sub_op) begin
      if (!shift16) begin
        s_nxt.carry = alu_cout;
      end else if (add_op) begin
        s_nxt.carry = s_r.carry | alu_cout;
      end else begin
        s_nxt.carry = s_r.carry & alu_cout;
      end
    end
    // [RULE_10] Single-bit shift and rotate carry
    if (shift_carry_we) begin
      s_nxt.carry = shift_carry_d;
    end
    if (test_flag_we) begin
      s_nxt.test_flag = test_flag_d;
    end
    if (shift_sel_we) begin
      s_nxt.product_shift_sel = shift_sel_d;
    end
    // [RULE_04] One bit per set or clear
    if (bit_op) begin
      case (cswl_pkg::cswl_bit_t'(bit_sel))
        cswl_pkg::CSWL_BIT_OVM: s_nxt.saturate_enable = bit_val;
        cswl_pkg::CSWL_BIT_GLOBAL_IRQ_MASK: s_nxt.global_irq_mask = bit_val;
        cswl_pkg::CSWL_BIT_CNF: s_nxt.ram_map_select = bit_val;
        cswl_pkg::CSWL_BIT_TC: s_nxt.test_flag = bit_val;
        cswl_pkg::CSWL_BIT_SXM: s_nxt.sign_extend_enable = bit_val;
        cswl_pkg::CSWL_BIT_C: s_nxt.carry = bit_val;
        cswl_pkg::CSWL_BIT_XF: s_nxt.general_out_flag = bit_val;
        default: s_nxt.carry = s_nxt.carry;
      endcase
    end
    // [RULE_03] Load-status, mask untouched
    if (load_status_op && !status_sel) begin
      s_nxt.aux_pointer = data_rd[cswl_pkg::CSWL_P0_ARP_LSB +: cswl_pkg::CSWL_ARP_W];
      s_nxt.arith_excess_latch = data_rd[cswl_pkg::CSWL_P0_OV];
      s_nxt.saturate_enable = data_rd[cswl_pkg::CSWL_P0_OVM];
      s_nxt.page_pointer = data_rd[cswl_pkg::CSWL_DP_W-1:0];
    end
    // [RULE_06] Buffer value also into pointer
    if (load_status_op && status_sel) begin
      s_nxt.aux_pointer_prev = data_rd[cswl_pkg::CSWL_P1_ARB_LSB +: cswl_pkg::CSWL_ARP_W];
      s_nxt.aux_pointer = data_rd[cswl_pkg::CSWL_P1_ARB_LSB +: cswl_pkg::CSWL_ARP_W];
      s_nxt.ram_map_select = data_rd[cswl_pkg::CSWL_P1_CNF];
      s_nxt.test_flag = data_rd[cswl_pkg::CSWL_P1_TC];
      s_nxt.sign_extend_enable = data_rd[cswl_pkg::CSWL_P1_SXM];
      s_nxt.carry = data_rd[cswl_pkg::CSWL_P1_C];
      s_nxt.general_out_flag = data_rd[cswl_pkg::CSWL_P1_XF];
      s_nxt.product_shift_sel = data_rd[cswl_pkg::CSWL_PM_W-1:0];
    end
    // [RULE_15] Sticky excess; a new event beats its clear
    if (cond_branch_op) begin
      s_nxt.arith_excess_latch = 1'h0;
    end
    if (alu_overflow) begin
      s_nxt.arith_excess_latch = 1'h1;
    end
    // [RULE_14] Ack and trap force the mask, over a clear
    if (irq_ack_cycle | trap_taken) begin
      s_nxt.global_irq_mask = 1'h1;
    end
    // [RULE_13] Mask gates only the maskable request
    s_nxt.irq_take = (maskable_irq_pend & ~s_r.global_irq_mask) | nmi_pend;
    if (store_status_op) begin
      s_nxt.store_q = status_sel ? word1 : word0;
    end
    // [RULE_18] Eight-deep shift stack; bottom repeats on pop
    if (stack_push) begin
      s_nxt.stk[0] = stack_d;
      for (int i = 1; i < cswl_pkg::CSWL_STK_DEPTH; i++) begin
        s_nxt.stk[i] = s_r.stk[i-1];
      end
    end else if (stack_pop) begin
      for (int i = 0; i < cswl_pkg::CSWL_STK_DEPTH - 1; i++) begin
        s_nxt.stk[i] = s_r.stk[i+1];
      end
    end
  end
  // ==========================================
  // State register
  // [RULE_25] Unspecified fields clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.arith_excess_latch <= cswl_pkg::CSWL_RST_OV;
      s_r.saturate_enable <= cswl_pkg::CSWL_RST_OVM;
      s_r.test_flag <= cswl_pkg::CSWL_RST_TC;
      s_r.aux_pointer <= cswl_pkg::CSWL_RST_ARP;
      s_r.aux_pointer_prev <= cswl_pkg::CSWL_RST_ARP;
      s_r.page_pointer <= cswl_pkg::CSWL_RST_DP;
      // [RULE_10] Carry reset one
      s_r.carry <= cswl_pkg::CSWL_RST_C;
      // [RULE_14] Mask set by reset
      s_r.global_irq_mask <= cswl_pkg::CSWL_RST_GLOBAL_IRQ_MASK;
      // [RULE_11] Map select cleared
      s_r.ram_map_select <= cswl_pkg::CSWL_RST_CNF;
      // [RULE_23] Sign extend set
      s_r.sign_extend_enable <= cswl_pkg::CSWL_RST_SXM;
      // [RULE_24] Output flag set
      s_r.general_out_flag <= cswl_pkg::CSWL_RST_XF;
      // [RULE_21] Shift select cleared
      s_r.product_shift_sel <= cswl_pkg::CSWL_RST_PM;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ==========================================
  // Multiplier unit
  // [RULE_20] Data read path apart from fetch path
  assign mb.shift_sel = s_r.product_shift_sel;
  assign mb.hold_we = hold_we;
  assign mb.hold_d = data_rd;
  assign mb.mul_go = mul_go;
  assign mb.mul_signed = mul_signed;
  assign mb.mul_b = data_rd;
  cswl_mul_unit u_mul (
    .clock(clock),
    .rst_b(rst_b),
    .mb(mb)
  );
  // ==========================================
  // Outputs
  // Scaled product stays combinational so the ALU sees it the same cycle
  assign product_scaled = mb.scaled;
  assign operand_hold = mb.hold;
  // [RULE_19] Shift count and bit position from hold
  assign dyn_shift_count = mb.hold[cswl_pkg::CSWL_SHCNT_W-1:0];
  // [RULE_12] Page over low instruction bits
  assign direct_addr = {s_r.page_pointer, instr_word[cswl_pkg::CSWL_DIR_W-1:0]};
  assign status_word_primary = word0;
  assign status_word_secondary = word1;
  assign status_store_data = s_r.store_q;
  assign aux_pointer = s_r.aux_pointer;
  assign irq_take = s_r.irq_take;
  // [RULE_22] Saturate mode to accumulator
  assign saturate_enable = s_r.saturate_enable;
  assign sign_extend_enable = s_r.sign_extend_enable;
  // [RULE_11] Map select to memory decode
  assign ram_map_select = s_r.ram_map_select;
  // [RULE_24] Output pin straight from flag
  assign general_out_flag = s_r.general_out_flag;
  assign stack_top = s_r.stk[0];
  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic carry_alu_only;
  assign carry_alu_only = !load_status_op && !shift_carry_we && !bit_op;
  sequence push_then_pop;
    stack_push ##1 (stack_pop && !stack_push);
  endsequence
  sequence excess_seen;
    alu_overflow ##1 (!cond_branch_op && !load_status_op);
  endsequence
  chk_lst_keeps_mask: assert property (load_status_op && !bit_op // [RULE_03]
    && !irq_ack_cycle && !trap_taken |=> $stable(s_r.global_irq_mask))
    else $error("load-status changed the mask");
  chk_ptr_history: assert property (arp_we && !load_status_op // [RULE_05]
    |=> s_r.aux_pointer_prev == $past(s_r.aux_pointer))
    else $error("buffer missed old pointer");
  chk_lst_ptr_follow: assert property (load_status_op && status_sel // [RULE_06]
    |=> s_r.aux_pointer == s_r.aux_pointer_prev
    && s_r.aux_pointer == $past(data_rd[15:13]))
    else $error("pointer not copied from buffer");
  chk_carry_plain: assert property ((add_op || sub_op) && !shift16 // [RULE_08]
    && carry_alu_only |=> s_r.carry == $past(alu_cout))
    else $error("carry not from ALU");
  chk_carry_wide: assert property (sub_op && shift16 && carry_alu_only // [RULE_09]
    && alu_cout |=> $stable(s_r.carry))
    else $error("shift-16 subtract changed carry without borrow");
  chk_excess_sticky: assert property (excess_seen |-> s_r.arith_excess_latch // [RULE_15]
    ##1 s_r.arith_excess_latch)
    else $error("excess latch dropped");
  chk_page_only: assert property (!page_load_op // [RULE_12]
    && !(load_status_op && !status_sel) |=> $stable(s_r.page_pointer))
    else $error("page changed by other op");
  chk_reserved_ones: assert property (store_status_op // [RULE_02]
    |=> (status_store_data & ($past(status_sel) ? 16'h01ec : 16'h0400))
    == ($past(status_sel) ? 16'h01ec : 16'h0400))
    else $error("reserved bit stored as zero");
  chk_mask_gate: assert property (maskable_irq_pend && !nmi_pend // [RULE_13]
    && s_r.global_irq_mask |=> !irq_take)
    else $error("masked request taken");
  chk_ack_sets_mask: assert property (irq_ack_cycle |=> s_r.global_irq_mask) // [RULE_14]
    else $error("ack left mask clear");
  chk_stack_lifo: assert property (push_then_pop |=> stack_top == $past(stack_top, 2)) // [RULE_18]
    else $error("stack pop wrong");
  chk_reset_values: assert property (@(posedge clock) disable iff (1'h0) !rst_b // [RULE_10]
    |=> s_r.carry && s_r.global_irq_mask && s_r.general_out_flag && s_r.sign_extend_enable
    && !s_r.ram_map_select && s_r.product_shift_sel == 2'h0)
    else $error("reset values wrong");
endmodule : cswl_status_core
`default_nettype wire

// ---- rtl/cswl_pkg.sv ----
// Purpose: Shared constants of the status word logic.
// Assumes: 16-bit data path.
// Notes: Field positions, reset values and codes.
`default_nettype none
package cswl_pkg;
  // ==========================================
  // Widths
  localparam int CSWL_W = 16;
  localparam int CSWL_ARP_W = 3;
  localparam int CSWL_DP_W = 9;
  localparam int CSWL_PM_W = 2;
  localparam int CSWL_DIR_W = 7;
  localparam int CSWL_SHCNT_W = 4;
  localparam int CSWL_STK_DEPTH = 8;
  // ==========================================
  // Field positions
  localparam int CSWL_P0_ARP_LSB = 13;
  localparam int CSWL_P0_OV = 12;
  localparam int CSWL_P0_OVM = 11;
  localparam int CSWL_P0_GLOBAL_IRQ_MASK = 9;
  localparam int CSWL_P1_ARB_LSB = 13;
  localparam int CSWL_P1_CNF = 12;
  localparam int CSWL_P1_TC = 11;
  localparam int CSWL_P1_SXM = 10;
  localparam int CSWL_P1_C = 9;
  localparam int CSWL_P1_XF = 4;
  localparam logic [15:0] CSWL_P0_RSV_MASK = 16'h0400;
  localparam logic [15:0] CSWL_P1_RSV_MASK = 16'h01ec;
  // ==========================================
  // Reset values
  localparam logic CSWL_RST_C = 1'h1;
  localparam logic CSWL_RST_GLOBAL_IRQ_MASK = 1'h1;
  localparam logic CSWL_RST_XF = 1'h1;
  localparam logic CSWL_RST_SXM = 1'h1;
  localparam logic CSWL_RST_CNF = 1'h0;
  localparam logic CSWL_RST_OV = 1'h0;
  localparam logic CSWL_RST_OVM = 1'h0;
  localparam logic CSWL_RST_TC = 1'h0;
  localparam logic [1:0] CSWL_RST_PM = 2'h0;
  localparam logic [2:0] CSWL_RST_ARP = 3'h0;
  localparam logic [8:0] CSWL_RST_DP = 9'h000;
  // ==========================================
  // Product shift amounts
  localparam int CSWL_SH_L1 = 1;
  localparam int CSWL_SH_L4 = 4;
  localparam int CSWL_SH_R6 = 6;
  typedef enum logic [1:0] {
    CSWL_PM_NONE = 2'h0,
    CSWL_PM_L1 = 2'h1,
    CSWL_PM_L4 = 2'h2,
    CSWL_PM_R6 = 2'h3
  } cswl_pm_t;
  // Bit codes for set and clear
  typedef enum logic [2:0] {
    CSWL_BIT_OVM = 3'h0,
    CSWL_BIT_GLOBAL_IRQ_MASK = 3'h1,
    CSWL_BIT_CNF = 3'h2,
    CSWL_BIT_TC = 3'h3,
    CSWL_BIT_SXM = 3'h4,
    CSWL_BIT_C = 3'h5,
    CSWL_BIT_XF = 3'h6
  } cswl_bit_t;
endpackage : cswl_pkg
`default_nettype wire

// ---- rtl/cswl_mul_if.sv ----
// Purpose: Link between status logic and multiplier unit.
// Assumes: Same clock on both sides.
// Notes: Scaled product is combinational from flops.
`timescale 1ns/1ps
`default_nettype none
interface cswl_mul_if;
  logic [1:0] shift_sel;
  logic hold_we;
  logic [15:0] hold_d;
  logic mul_go;
  logic mul_signed;
  logic [15:0] mul_b;
  logic [31:0] product;
  logic [31:0] scaled;
  logic [15:0] hold;
  modport core (output shift_sel, hold_we, hold_d, mul_go, mul_signed, mul_b,
    input product, scaled, hold);
  modport unit (input shift_sel, hold_we, hold_d, mul_go, mul_signed, mul_b,
    output product, scaled, hold);
endinterface : cswl_mul_if
`default_nettype wire

// ---- rtl/cswl_mul_unit.sv ----
// Purpose: Operand hold, product register and product scaler.
// Assumes: Strobes from the status logic, one per cycle.
// Notes: Scaler sits after the register, no added cycle.
`timescale 1ns/1ps
`default_nettype none
module cswl_mul_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Core side
  cswl_mul_if.unit mb
);
  typedef struct packed {
    logic [31:0] product;
    logic [15:0] hold;
  } cswl_mu_t;
  cswl_mu_t s_r;
  cswl_mu_t s_nxt;
  logic signed [16:0] a_x;
  logic signed [16:0] b_x;
  logic signed [33:0] prod_x;
  // ==========================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    a_x = {mb.mul_signed & s_r.hold[15], s_r.hold};
    b_x = {mb.mul_signed & mb.mul_b[15], mb.mul_b};
    prod_x = a_x * b_x;
    if (mb.hold_we) begin
      s_nxt.hold = mb.hold_d;
    end
    // [RULE_16] Full product capture
    if (mb.mul_go) begin
      s_nxt.product = prod_x[31:0];
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ==========================================
  // Scaler
  // [RULE_17] Shift on the way out
  // [RULE_21] Zero fill left, sign fill right
  always_comb begin
    unique case (cswl_pkg::cswl_pm_t'(mb.shift_sel))
      cswl_pkg::CSWL_PM_NONE: mb.scaled = s_r.product;
      cswl_pkg::CSWL_PM_L1: mb.scaled = s_r.product << cswl_pkg::CSWL_SH_L1;
      cswl_pkg::CSWL_PM_L4: mb.scaled = s_r.product << cswl_pkg::CSWL_SH_L4;
      cswl_pkg::CSWL_PM_R6: mb.scaled = 32'($signed(s_r.product) >>> cswl_pkg::CSWL_SH_R6);
    endcase
  end
  assign mb.product = s_r.product;
  // [RULE_19] Hold supplies one multiplier operand
  assign mb.hold = s_r.hold;
  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // [RULE_16] Capture check
  chk_product_capture: assert property (mb.mul_go |=> mb.product == $past(prod_x[31:0])) // [RULE_16]
    else $error("product not captured");
  chk_scale_right: assert property (mb.shift_sel == 2'h3 |-> mb.scaled[31:26] == {6{mb.product[31]}}) // [RULE_21]
    else $error("right scale not sign filled");
  chk_scale_left: assert property (mb.shift_sel == 2'h2 |-> mb.scaled == {mb.product[27:0], 4'h0}) // [RULE_17]
    else $error("left four scale wrong");
endmodule : cswl_mul_unit
`default_nettype wire

// ---- verif/cswl_status_core_tb_top.sv ----
// Purpose: Self-checking bench for the status word logic.
// Assumes: One clock, synchronous active-low reset, one-cycle op strobes.
// Notes: Secondary word reset includes carry at one, so it reads 16'h07fc.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t %s got %h exp %h", $time, m, a, e); end end
module cswl_status_core_tb_top;
  // ==========================================
  // Stimulus and observed signals
  logic clock = 1'h0, rst_b = 1'h0, status_sel = 1'h0, load_status_op = 1'h0;
  logic store_status_op = 1'h0, bit_set_op = 1'h0, bit_clear_op = 1'h0, page_load_op = 1'h0;
  logic indirect_ref_op = 1'h0, aux_pointer_load_op = 1'h0, modify_aux_op = 1'h0;
  logic add_op = 1'h0, sub_op = 1'h0, shift16 = 1'h0, alu_cout = 1'h0, alu_overflow = 1'h0;
  logic shift_carry_we = 1'h0, shift_carry_d = 1'h0, test_flag_we = 1'h0, test_flag_d = 1'h0;
  logic shift_sel_we = 1'h0, cond_branch_op = 1'h0, irq_ack_cycle = 1'h0, trap_taken = 1'h0;
  logic maskable_irq_pend = 1'h0, nmi_pend = 1'h0, hold_we = 1'h0, mul_go = 1'h0;
  logic mul_signed = 1'h0, stack_push = 1'h0, stack_pop = 1'h0;
  logic [15:0] data_rd = 16'h0000, instr_word = 16'h0000, stack_d = 16'h0000;
  logic [2:0] bit_sel = 3'h0, aux_pointer_d = 3'h0;
  logic [8:0] page_pointer_d = 9'h000;
  logic [1:0] shift_sel_d = 2'h0;
  logic [15:0] status_store_data, status_word_primary, status_word_secondary;
  logic [15:0] operand_hold, stack_top, direct_addr;
  logic [2:0] aux_pointer;
  logic irq_take, saturate_enable, sign_extend_enable, ram_map_select, general_out_flag;
  logic [31:0] product_scaled;
  logic [3:0] dyn_shift_count;
  logic [31:0] prod;
  logic [31:0] exp_sc;
  int num_errors = 0;
  int total_checks = 0;
  typedef struct {logic s; logic c; logic [2:0] sel; logic [15:0] p0; logic [15:0] p1;} cswl_row_t;
  // Rows run in order from reset; each row builds on the one before
  cswl_row_t rows [8] = '{
    '{1'h1, 1'h0, 3'h0, 16'h0e00, 16'h07fc}, '{1'h0, 1'h1, 3'h1, 16'h0c00, 16'h07fc},
    '{1'h1, 1'h0, 3'h2, 16'h0c00, 16'h17fc}, '{1'h1, 1'h0, 3'h3, 16'h0c00, 16'h1ffc},
    '{1'h0, 1'h1, 3'h4, 16'h0c00, 16'h1bfc}, '{1'h0, 1'h1, 3'h5, 16'h0c00, 16'h19fc},
    '{1'h0, 1'h1, 3'h6, 16'h0c00, 16'h19ec}, '{1'h1, 1'h0, 3'h7, 16'h0c00, 16'h19ec}};

  always #25 clock = ~clock;

  cswl_status_core u_dut (.clock, .rst_b, .load_status_op, .store_status_op, .status_sel,
    .data_rd, .status_store_data, .status_word_primary, .status_word_secondary, .bit_set_op,
    .bit_clear_op, .bit_sel, .indirect_ref_op, .aux_pointer_load_op, .modify_aux_op,
    .aux_pointer_d, .page_load_op, .page_pointer_d, .instr_word, .direct_addr, .aux_pointer,
    .add_op, .sub_op, .shift16, .alu_cout, .alu_overflow, .shift_carry_we, .shift_carry_d,
    .test_flag_we, .test_flag_d, .shift_sel_we, .shift_sel_d, .cond_branch_op, .irq_ack_cycle,
    .trap_taken, .maskable_irq_pend, .nmi_pend, .irq_take, .saturate_enable,
    .sign_extend_enable, .ram_map_select, .general_out_flag, .hold_we, .mul_go, .mul_signed,
    .product_scaled, .operand_hold, .dyn_shift_count, .stack_push, .stack_pop, .stack_d,
    .stack_top);

  // ==========================================
  // Tasks
  // Inputs move 2 ns after the edge so the design never races the bench
  task automatic tick;
    @(posedge clock);
    #2;
  endtask : tick
  task automatic fin(input string n);
    $display("test %s done, mismatches so far %0d", n, num_errors);
  endtask : fin
  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic alu(input logic a, input logic s, input logic sh, input logic co,
                     input logic e);
    add_op = a;
    sub_op = s;
    shift16 = sh;
    alu_cout = co;
    tick;
    `CHK(status_word_secondary[9], e, "carry")
  endtask : alu

  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    #2;
    rst_b = 1'h1;
    `CHK(status_word_primary, 16'h0600, "reset primary")
    `CHK(status_word_secondary, 16'h07fc, "reset secondary")
    `CHK({general_out_flag, sign_extend_enable, ram_map_select}, 3'h6, "reset modes")
    `CHK(irq_take, 1'h0, "reset irq")
    foreach (rows[i]) begin
      bit_set_op = rows[i].s;
      bit_clear_op = rows[i].c;
      bit_sel = rows[i].sel;
      tick;
      `CHK(status_word_primary, rows[i].p0, "bit op primary")
      `CHK(status_word_secondary, rows[i].p1, "bit op secondary")
    end
    bit_set_op = 1'h0;
    bit_clear_op = 1'h0;
    `CHK({general_out_flag, saturate_enable}, 2'h1, "out flag pin")
    fin("bit ops");
    load_status_op = 1'h1;
    status_sel = 1'h1;
    data_rd = 16'h6000;
    tick;
    `CHK(status_word_secondary, 16'h61ec, "load secondary")
    `CHK(status_word_primary, 16'h6c00, "pointer from buffer")
    status_sel = 1'h0;
    data_rd = 16'h0205;
    tick;
    `CHK(status_word_primary, 16'h0405, "load keeps mask")
    `CHK(status_word_secondary, 16'h61ec, "no buffer copy on load")
    load_status_op = 1'h0;
    aux_pointer_load_op = 1'h1;
    aux_pointer_d = 3'h6;
    tick;
    `CHK(status_word_secondary, 16'h01ec, "old pointer to buffer")
    aux_pointer_load_op = 1'h0;
    indirect_ref_op = 1'h1;
    aux_pointer_d = 3'h2;
    tick;
    indirect_ref_op = 1'h0;
    modify_aux_op = 1'h1;
    aux_pointer_d = 3'h1;
    tick;
    `CHK({aux_pointer, status_word_secondary}, 19'h141ec, "pointer chain")
    modify_aux_op = 1'h0;
    store_status_op = 1'h1;
    status_sel = 1'h1;
    instr_word = 16'hffff;
    tick;
    store_status_op = 1'h0;
    `CHK(status_store_data, 16'h41ec, "store secondary")
    `CHK(direct_addr, 16'h02ff, "direct address")
    page_load_op = 1'h1;
    page_pointer_d = 9'h1ff;
    instr_word = 16'h0080;
    tick;
    page_load_op = 1'h0;
    `CHK(direct_addr, 16'hff80, "paged address")
    fin("load store");
    alu(1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    alu(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    alu(1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    alu(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    alu(1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    alu(1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    alu(1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
    alu(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    add_op = 1'h0;
    sub_op = 1'h0;
    shift_carry_we = 1'h1;
    shift_carry_d = 1'h1;
    test_flag_we = 1'h1;
    test_flag_d = 1'h1;
    tick;
    shift_carry_we = 1'h0;
    test_flag_we = 1'h0;
    `CHK(status_word_secondary, 16'h4bec, "shift carry and test")
    alu_overflow = 1'h1;
    tick;
    alu_overflow = 1'h0;
    tick;
    `CHK(status_word_primary[12], 1'h1, "excess sticky")
    cond_branch_op = 1'h1;
    tick;
    cond_branch_op = 1'h0;
    `CHK(status_word_primary[12], 1'h0, "excess cleared")
    maskable_irq_pend = 1'h1;
    tick;
    `CHK(irq_take, 1'h1, "irq open")
    irq_ack_cycle = 1'h1;
    tick;
    irq_ack_cycle = 1'h0;
    tick;
    `CHK(irq_take, 1'h0, "irq masked")
    nmi_pend = 1'h1;
    tick;
    `CHK(irq_take, 1'h1, "nmi passes mask")
    nmi_pend = 1'h0;
    maskable_irq_pend = 1'h0;
    bit_clear_op = 1'h1;
    bit_sel = 3'h1;
    tick;
    bit_clear_op = 1'h0;
    trap_taken = 1'h1;
    tick;
    trap_taken = 1'h0;
    `CHK(status_word_primary[9], 1'h1, "trap sets mask")
    fin("carry excess irq");
    hold_we = 1'h1;
    data_rd = 16'hfffd;
    tick;
    hold_we = 1'h0;
    mul_go = 1'h1;
    mul_signed = 1'h1;
    data_rd = 16'h0100;
    tick;
    mul_go = 1'h0;
    `CHK(dyn_shift_count, 4'hd, "shift count")
    `CHK(operand_hold, 16'hfffd, "operand hold")
    prod = 32'hfffffd00;
    shift_sel_we = 1'h1;
    for (int k = 0; k < 4; k++) begin
      shift_sel_d = k[1:0];
      tick;
      exp_sc = (k == 3) ? {{6{prod[31]}}, prod[31:6]} : prod << ((k == 2) ? 4 : k);
      `CHK(product_scaled, exp_sc, "scaled product")
    end
    shift_sel_we = 1'h0;
    `CHK(status_word_secondary[1:0], 2'h3, "shift select field")
    mul_go = 1'h1;
    mul_signed = 1'h0;
    tick;
    mul_go = 1'h0;
    `CHK(product_scaled, 32'h0003fff4, "unsigned product")
    stack_push = 1'h1;
    stack_d = 16'h1234;
    tick;
    stack_d = 16'habcd;
    tick;
    stack_push = 1'h0;
    `CHK(stack_top, 16'habcd, "stack push")
    stack_pop = 1'h1;
    tick;
    stack_pop = 1'h0;
    `CHK(stack_top, 16'h1234, "stack pop")
    rst_b = 1'h0;
    tick;
    rst_b = 1'h1;
    `CHK(status_word_secondary, 16'h07fc, "second reset")
    `CHK({status_word_primary, stack_top}, 32'h06000000, "second reset")
    fin("product stack reset");
    test_done;
  end

  // Whole run is about 47 cycles; a hang is cut off well beyond that
  initial begin
    #20000;
    num_errors++;
    $display("mismatch t=%0t watchdog expired", $time);
    test_done;
  end
endmodule : cswl_status_core_tb_top
`default_nettype wire
